// [nfh_defs.vh]
// Constants for the NAND flash host sequencer
`ifndef NFH_DEFS_VH
`define NFH_DEFS_VH
`define NFH_CMD_READ1 8'h00
`define NFH_CMD_READ2 8'h30
`define NFH_CMD_PROG1 8'h80
`define NFH_CMD_PROG2 8'h10
`define NFH_CMD_ERASE1 8'h60
`define NFH_CMD_ERASE2 8'hD0
`define NFH_CMD_STATUS 8'h70
`define NFH_CMD_RESET 8'hFF
`define NFH_BAD_MARK 8'h00
`define NFH_STAT_FAIL_BIT 0
`define NFH_BLOCKS 2048
`define NFH_MIN_GOOD 2008
`define NFH_MAX_PARTIAL 3'h4
`define NFH_OP_READ 2'h0
`define NFH_OP_PROG 2'h1
`define NFH_OP_ERASE 2'h2
`define NFH_OP_CHECK 2'h3
`endif

// [nfh_host.v]
// NAND flash host sequencer: issues pin cycles and keeps a bad block table
`timescale 1ns/100ps
`include "nfh_defs.vh"
module nfh_host #(
  parameter BLK_W = 11,
  parameter PG_W = 6,
  parameter NBLK = 2048
) (
  clk,
  rst_n,
  op_valid,
  op_code,
  op_block,
  op_page,
  op_column,
  op_data,
  op_ready,
  done_ff,
  fail_ff,
  refused_ff,
  rdata_ff,
  bad_count_ff,
  cle_ff,
  ale_ff,
  ce_n_ff,
  we_n_ff,
  re_n_ff,
  wp_n_ff,
  io_in,
  io_out_ff,
  io_oe_ff,
  ready_busy_output
);
  input wire clk;
  input wire rst_n;
  input wire op_valid;
  input wire [1:0] op_code;
  input wire [BLK_W-1:0] op_block;
  input wire [PG_W-1:0] op_page;
  input wire [11:0] op_column;
  input wire [7:0] op_data;
  output wire op_ready;
  output reg done_ff;
  output reg fail_ff;
  output reg refused_ff;
  output reg [7:0] rdata_ff;
  output reg [BLK_W:0] bad_count_ff;
  output reg cle_ff;
  output reg ale_ff;
  output reg ce_n_ff;
  output reg we_n_ff;
  output reg re_n_ff;
  output reg wp_n_ff;
  input wire [7:0] io_in;
  output reg [7:0] io_out_ff;
  output reg io_oe_ff;
  input wire ready_busy_output;

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE = 4'h0, S_CMD1 = 4'h1, S_ADDR = 4'h2, S_DATA = 4'h3, S_CMD2 = 4'h4, S_WAIT = 4'h5;
  localparam S_STAT = 4'h6, S_SRD = 4'h7, S_RD = 4'h8, S_FIN = 4'h9, S_RST = 4'hA;

  reg [3:0] st_ff;
  reg [1:0] op_ff;
  reg [BLK_W-1:0] blk_ff, part_blk_ff;
  reg [PG_W-1:0] pg_ff, part_pg_ff;
  reg [11:0] col_ff;
  reg [7:0] dat_ff;
  reg [2:0] acnt_ff, acyc_ff, part_ff;
  reg ph_ff, rdy_ff;
  reg [NBLK-1:0] bad_ff;
  reg [PG_W:0] next_pg_ff [0:NBLK-1];
  integer i;

  // Address byte n of the five-byte column and row address; erase cycles use n = 2 to 4
  function [7:0] addr_byte;
    input [2:0] n;
    input [11:0] col;
    input [PG_W-1:0] pg;
    input [BLK_W-1:0] blk;
    reg [23:0] row;
    begin
      row = {{(24-PG_W-BLK_W){1'b0}}, blk, pg};
      case (n)
        3'h0: addr_byte = col[7:0];
        3'h1: addr_byte = {4'h0, col[11:8]};
        3'h2: addr_byte = row[7:0];
        3'h3: addr_byte = row[15:8];
        default: addr_byte = row[23:16];
      endcase
    end
  endfunction

  // Refusal checks at issue time
  wire is_bad = bad_ff[op_block];
  wire same_pg = (part_blk_ff == op_block) && (part_pg_ff == op_page);
  wire same_cur = (part_blk_ff == blk_ff) && (part_pg_ff == pg_ff);
  wire pg_bad_order = ({1'b0, op_page} < next_pg_ff[op_block]) && !same_pg;
  wire part_over = same_pg && (part_ff == `NFH_MAX_PARTIAL);
  wire refuse = ((op_code == `NFH_OP_ERASE || op_code == `NFH_OP_READ) && is_bad) ||
                ((op_code == `NFH_OP_PROG) && (is_bad || pg_bad_order || part_over));
  assign op_ready = rdy_ff;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= S_RST;
      op_ff <= 2'h0;
      blk_ff <= {BLK_W{1'b0}};
      pg_ff <= {PG_W{1'b0}};
      col_ff <= 12'h000;
      dat_ff <= 8'h00;
      acnt_ff <= 3'h0;
      acyc_ff <= 3'h0;
      ph_ff <= 1'b0;
      rdy_ff <= 1'b0;
      bad_ff <= {NBLK{1'b0}};
      part_ff <= 3'h0;
      part_pg_ff <= {PG_W{1'b0}};
      part_blk_ff <= {BLK_W{1'b0}};
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      refused_ff <= 1'b0;
      rdata_ff <= 8'h00;
      bad_count_ff <= {(BLK_W+1){1'b0}};
      cle_ff <= 1'b0;
      ale_ff <= 1'b0;
      ce_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      re_n_ff <= 1'b1;
      wp_n_ff <= 1'b0;
      io_out_ff <= 8'h00;
      io_oe_ff <= 1'b0;
      for (i = 0; i < NBLK; i = i + 1) begin
        next_pg_ff[i] <= {(PG_W+1){1'b0}};
      end
    end else begin
      done_ff <= 1'b0;
      refused_ff <= 1'b0;
      ph_ff <= ~ph_ff;
      case (st_ff)
        S_RST: begin
          ce_n_ff <= 1'b0;
          cle_ff <= 1'b1;
          io_oe_ff <= 1'b1;
          io_out_ff <= `NFH_CMD_RESET;
          we_n_ff <= ph_ff;
          if (ph_ff) begin
            cle_ff <= 1'b0;
            io_oe_ff <= 1'b0;
            wp_n_ff <= 1'b1;
            st_ff <= S_WAIT;
            op_ff <= `NFH_OP_READ;
            acnt_ff <= 3'h7;
          end
        end
        S_IDLE: begin
          ph_ff <= 1'b0;
          ce_n_ff <= 1'b1;
          if (op_valid) begin
            if (refuse) begin
              refused_ff <= 1'b1;
              done_ff <= 1'b1;
            end else begin
              op_ff <= op_code;
              blk_ff <= op_block;
              pg_ff <= op_page;
              col_ff <= op_column;
              dat_ff <= op_data;
              acnt_ff <= 3'h0;
              // Erase takes row cycles only
              acyc_ff <= (op_code == `NFH_OP_ERASE) ? 3'h3 : 3'h5;
              ce_n_ff <= 1'b0;
              rdy_ff <= 1'b0;
              st_ff <= S_CMD1;
            end
          end
        end
        S_CMD1: begin
          cle_ff <= 1'b1;
          io_oe_ff <= 1'b1;
          io_out_ff <= (op_ff == `NFH_OP_PROG) ? `NFH_CMD_PROG1 :
                       (op_ff == `NFH_OP_ERASE) ? `NFH_CMD_ERASE1 : `NFH_CMD_READ1;
          we_n_ff <= ph_ff;
          if (ph_ff) begin
            cle_ff <= 1'b0;
            st_ff <= S_ADDR;
          end
        end
        S_ADDR: begin
          ale_ff <= 1'b1;
          io_out_ff <= (op_ff == `NFH_OP_ERASE) ? addr_byte(acnt_ff + 3'h2, col_ff, pg_ff, blk_ff) :
                       addr_byte(acnt_ff, col_ff, pg_ff, blk_ff);
          we_n_ff <= ph_ff;
          if (ph_ff) begin
            if (acnt_ff == acyc_ff - 3'h1) begin
              ale_ff <= 1'b0;
              st_ff <= (op_ff == `NFH_OP_PROG) ? S_DATA : S_CMD2;
            end
            acnt_ff <= acnt_ff + 3'h1;
          end
        end
        S_DATA: begin
          io_out_ff <= dat_ff;
          we_n_ff <= ph_ff;
          if (ph_ff) begin
            st_ff <= S_CMD2;
          end
        end
        S_CMD2: begin
          cle_ff <= 1'b1;
          io_out_ff <= (op_ff == `NFH_OP_PROG) ? `NFH_CMD_PROG2 :
                       (op_ff == `NFH_OP_ERASE) ? `NFH_CMD_ERASE2 : `NFH_CMD_READ2;
          we_n_ff <= ph_ff;
          if (ph_ff) begin
            cle_ff <= 1'b0;
            io_oe_ff <= 1'b0;
            acnt_ff <= 3'h0;
            st_ff <= S_WAIT;
          end
        end
        S_WAIT: begin
          // wait for ready; nothing issued while busy
          if (ready_busy_output && ph_ff) begin
            if (acnt_ff == 3'h7) begin
              rdy_ff <= 1'b1;
              st_ff <= S_IDLE;
            end else begin
              st_ff <= (op_ff == `NFH_OP_READ || op_ff == `NFH_OP_CHECK) ? S_RD : S_STAT;
            end
          end
        end
        S_STAT: begin
          cle_ff <= 1'b1;
          io_oe_ff <= 1'b1;
          io_out_ff <= `NFH_CMD_STATUS;
          we_n_ff <= ph_ff;
          if (ph_ff) begin
            cle_ff <= 1'b0;
            io_oe_ff <= 1'b0;
            st_ff <= S_SRD;
          end
        end
        S_SRD: begin
          re_n_ff <= ph_ff;
          if (ph_ff) begin
            fail_ff <= io_in[`NFH_STAT_FAIL_BIT];
            if (io_in[`NFH_STAT_FAIL_BIT]) begin
              bad_count_ff <= bad_count_ff + {{BLK_W{1'b0}}, !bad_ff[blk_ff]};
              bad_ff[blk_ff] <= 1'b1;
            end else if (op_ff == `NFH_OP_ERASE) begin
              next_pg_ff[blk_ff] <= {(PG_W+1){1'b0}};
              part_ff <= 3'h0;
            end else begin
              next_pg_ff[blk_ff] <= {1'b0, pg_ff} + 1'b1;
              part_ff <= same_cur ? part_ff + 3'h1 : 3'h1;
              part_pg_ff <= pg_ff;
              part_blk_ff <= blk_ff;
            end
            st_ff <= S_FIN;
          end
        end
        S_RD: begin
          re_n_ff <= ph_ff;
          if (ph_ff) begin
            rdata_ff <= io_in;
            fail_ff <= 1'b0;
            // zero marker means bad; count kept, any total tolerated
            if (op_ff == `NFH_OP_CHECK && io_in == `NFH_BAD_MARK) begin
              bad_count_ff <= bad_count_ff + {{BLK_W{1'b0}}, !bad_ff[blk_ff]};
              bad_ff[blk_ff] <= 1'b1;
            end
            st_ff <= S_FIN;
          end
        end
        S_FIN: begin
          ce_n_ff <= 1'b1;
          done_ff <= 1'b1;
          rdy_ff <= 1'b1;
          st_ff <= S_IDLE;
        end
        default: begin
          rdy_ff <= 1'b1;
          st_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// [nfh_flash_model.sv]
// Flash array model answering the host sequencer pins
`timescale 1ns/100ps
module nfh_flash_model #(parameter BAD = 3) (
  input wire clk,
  input wire cle,
  input wire ale,
  input wire ce_n,
  input wire we_n,
  input wire re_n,
  input wire wp_n,
  input wire [7:0] din,
  input wire [10:0] fail_blk,
  output wire [7:0] dout,
  output wire rdy
);
  // ----
  // Strobe decode
  // ----
  reg [7:0] a_ff [0:4];
  reg [7:0] mem_ff, dat_ff;
  reg [2:0] idx_ff;
  reg [4:0] bsy_ff = 5'h00;
  reg wq_ff = 1'b1, stat_ff = 1'b0, sf_ff = 1'b0;
  // Pins as they stood while the strobe was low; the host drops cle and ale with the rising strobe
  reg cq_ff = 1'b0, aq_ff = 1'b0, cen_ff = 1'b1;
  reg [7:0] dq_ff = 8'h00;
  wire [23:0] row = {a_ff[4], a_ff[3], a_ff[2]};
  wire hit = row[16:6] == fail_blk;
  wire lat = we_n && !wq_ff && !cen_ff;
  wire [7:0] q = stat_ff ? {wp_n, rdy, rdy, 4'h0, sf_ff} : (row[16:6] == BAD ? 8'h00 : mem_ff);
  // Released bus never shows a stale byte
  assign dout = (re_n || ce_n) ? ~q : q;
  assign rdy = bsy_ff == 5'h00;
  always @(posedge clk) begin
    wq_ff <= we_n;
    cq_ff <= cle;
    aq_ff <= ale;
    cen_ff <= ce_n;
    dq_ff <= din;
    if (!rdy)
      bsy_ff <= bsy_ff - 5'h01;
    if (lat && cq_ff) begin
      if (dq_ff == 8'h70)
        stat_ff <= 1'b1;
      else if (dq_ff == 8'h00)
        stat_ff <= 1'b0;
      if (dq_ff == 8'h00 || dq_ff == 8'h80 || dq_ff == 8'h60)
        idx_ff <= (dq_ff == 8'h60) ? 3'h2 : 3'h0;
      if (dq_ff == 8'h30 || dq_ff == 8'h10 || dq_ff == 8'hD0 || dq_ff == 8'hFF)
        bsy_ff <= 5'h14;
      if (dq_ff == 8'h10 || dq_ff == 8'hD0)
        sf_ff <= hit;
      if (dq_ff == 8'h10 && !hit)
        mem_ff <= dat_ff;
    end
    // write protect low ends any busy time (read, program, erase or reset); program data is still stored
    if (!wp_n)
      bsy_ff <= 5'h00;
    if (lat && aq_ff && idx_ff < 3'h5)
      a_ff[idx_ff] <= dq_ff;
    if (lat && aq_ff)
      idx_ff <= idx_ff + 3'h1;
    if (lat && !cq_ff && !aq_ff)
      dat_ff <= dq_ff;
  end
endmodule

// [nfh_host_props.sv]
// Port checker for the host sequencer
`timescale 1ns/100ps
module nfh_host_props #(parameter BLK_W = 11) (
  input wire clk,
  input wire rst_n,
  input wire op_valid,
  input wire op_ready,
  input wire done_ff,
  input wire refused_ff,
  input wire [BLK_W:0] bad_count_ff,
  input wire cle_ff,
  input wire ce_n_ff,
  input wire we_n_ff,
  input wire re_n_ff,
  input wire wp_n_ff,
  input wire [7:0] io_out_ff,
  input wire io_oe_ff,
  input wire ready_busy_output
);
  // ----
  // Port relations
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  done_pulse_a: assert property (done_ff |=> !done_ff)
    else $error("done too long");
  refuse_done_a: assert property (refused_ff |-> done_ff)
    else $error("refusal without done");
  take_drop_a: assert property (op_valid && op_ready |=> op_ready == refused_ff)
    else $error("ready not matching refusal after take");
  ready_done_a: assert property (done_ff && !refused_ff |-> ready_busy_output)
    else $error("done while busy");
  busy_cmd_a: assert property (!ready_busy_output && cle_ff && !we_n_ff |-> (io_out_ff == 8'h70 || io_out_ff == 8'hFF))
    else $error("command while busy");
  read_float_a: assert property (!re_n_ff |-> !io_oe_ff && !ce_n_ff)
    else $error("drive during read");
  bad_step_a: assert property ($changed(bad_count_ff) |-> bad_count_ff == $past(bad_count_ff) + 1)
    else $error("bad count jump");
  reset_pins_a: assert property (disable iff (1'b0) !rst_n |=> ce_n_ff && !wp_n_ff && !io_oe_ff)
    else $error("pins active in reset");
endmodule

// [test_nfh_host.sv]
// Self-checking bench for the host sequencer
`timescale 1ns/100ps
module test_nfh_host;
  reg clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0;
  reg [1:0] op_code = 2'h0;
  reg [10:0] op_block = 11'h000, fail_blk = 11'h7FF;
  reg [5:0] op_page = 6'h00;
  reg [7:0] op_data = 8'h00;
  wire op_ready, done_ff, fail_ff, refused_ff, cle_ff, ale_ff, ce_n_ff, we_n_ff, re_n_ff, wp_n_ff, io_oe_ff, rb;
  wire [7:0] rdata_ff, io_in, io_out_ff;
  wire [11:0] bad_count_ff;
  integer fail_count = 0, n_checks = 0, i;
  always #50 clk = ~clk;
  nfh_host uut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code), .op_block(op_block),
    .op_page(op_page), .op_column(12'h005), .op_data(op_data), .op_ready(op_ready), .done_ff(done_ff),
    .fail_ff(fail_ff), .refused_ff(refused_ff), .rdata_ff(rdata_ff), .bad_count_ff(bad_count_ff),
    .cle_ff(cle_ff), .ale_ff(ale_ff), .ce_n_ff(ce_n_ff), .we_n_ff(we_n_ff), .re_n_ff(re_n_ff),
    .wp_n_ff(wp_n_ff), .io_in(io_in), .io_out_ff(io_out_ff), .io_oe_ff(io_oe_ff), .ready_busy_output(rb));
  nfh_flash_model dev (.clk(clk), .cle(cle_ff), .ale(ale_ff), .ce_n(ce_n_ff), .we_n(we_n_ff), .re_n(re_n_ff),
    .wp_n(wp_n_ff), .din(io_out_ff), .fail_blk(fail_blk), .dout(io_in), .rdy(rb));
  // ----
  // Tasks
  // ----
  task chk(input [8*8:1] nm, input [11:0] e, input [11:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("unexpected %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task op(input [1:0] c, input [10:0] b, input [5:0] p, input [7:0] d);
    integer k;
    begin
      k = 0;
      @(negedge clk);
      while (op_ready !== 1'b1 && k < 9000) begin
        @(negedge clk);
        k = k + 1;
      end
      op_code = c;
      op_block = b;
      op_page = p;
      op_data = d;
      op_valid = 1'b1;
      @(negedge clk);
      op_valid = 1'b0;
      while (done_ff !== 1'b1 && k < 9000) begin
        @(negedge clk);
        k = k + 1;
      end
      if (k >= 9000)
        chk("timeout", 12'h000, 12'h001);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    op(2'h1, 11'h001, 6'h00, 8'h5A);
    chk("prog", 12'h000, {refused_ff, fail_ff});
    op(2'h0, 11'h001, 6'h00, 8'h00);
    chk("rdata", 12'h05A, rdata_ff);
    chk("badcnt", 12'h000, bad_count_ff);
    $display("read write test done");
    op(2'h1, 11'h001, 6'h02, 8'h11);
    op(2'h1, 11'h001, 6'h01, 8'h22);
    chk("order", 12'h001, refused_ff);
    $display("page order test done");
    for (i = 0; i < 4; i = i + 1) begin
      op(2'h1, 11'h001, 6'h02, 8'h33);
      chk("partial", (i == 3) ? 12'h001 : 12'h000, refused_ff);
    end
    $display("partial test done");
    op(2'h3, 11'h003, 6'h00, 8'h00);
    chk("marker", 12'h000, rdata_ff);
    chk("badcnt", 12'h001, bad_count_ff);
    op(2'h2, 11'h003, 6'h00, 8'h00);
    chk("erasebad", 12'h001, refused_ff);
    $display("bad block test done");
    fail_blk = 11'h004;
    op(2'h2, 11'h004, 6'h00, 8'h00);
    chk("efail", 12'h001, fail_ff);
    chk("badcnt", 12'h002, bad_count_ff);
    op(2'h1, 11'h004, 6'h00, 8'h44);
    chk("failblk", 12'h001, refused_ff);
    $display("failure test done");
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count = fail_count + 1;
    summarize;
  end
endmodule
bind nfh_host nfh_host_props #(.BLK_W(BLK_W)) chk_u (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
  .op_ready(op_ready), .done_ff(done_ff), .refused_ff(refused_ff), .bad_count_ff(bad_count_ff),
  .cle_ff(cle_ff), .ce_n_ff(ce_n_ff), .we_n_ff(we_n_ff), .re_n_ff(re_n_ff), .wp_n_ff(wp_n_ff),
  .io_out_ff(io_out_ff), .io_oe_ff(io_oe_ff), .ready_busy_output(ready_busy_output));
